// [hw/dvi_pkg.sv]
// ============================================================
// shared constants for the delta angle / delta velocity block
// ============================================================
package dvi_pkg;

    // ========================================================
    // timing
    // ========================================================
    localparam int CLK_FREQ_HZ     = 40_000_000; // system clock rate
    localparam int SAMPLE_RATE_SPS = 2000;       // internal sample rate
    // cycles per internal sample, exact at 40 MHz
    localparam int SAMPLE_DIV_CYC  = CLK_FREQ_HZ / SAMPLE_RATE_SPS;
    localparam int DIV_W           = 16;         // divider counter width

    // ========================================================
    // data path widths
    // ========================================================
    localparam int SAMPLE_W  = 16;  // width of one inertial sample
    localparam int ACC_W     = 48;  // accumulator width
    localparam int RES_W     = 32;  // combined result width
    localparam int WORD_W    = 16;  // one register word
    localparam int DEC_W     = 16;  // decimation setting width
    localparam int ADDR_W    = 7;   // register byte address width
    localparam int GAIN_SHIFT = 1;  // divide by two of the trapezoid

    // ========================================================
    // reset values
    // ========================================================
    localparam logic [RES_W-1:0]  RES_RST  = 32'h00000000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

    // ========================================================
    // saturation limits of the 32-bit result
    // ========================================================
    localparam logic [RES_W-1:0] RES_POS_MAX = 32'h7FFFFFFF;
    localparam logic [RES_W-1:0] RES_NEG_MAX = 32'h80000000;

    // ========================================================
    // register byte offsets (read only)
    // ========================================================
    localparam logic [ADDR_W-1:0] X_ANGLE_INCREMENT_LOW  = 7'h24;
    localparam logic [ADDR_W-1:0] X_ANGLE_INCREMENT_HIGH = 7'h26;
    localparam logic [ADDR_W-1:0] Y_ANGLE_INCREMENT_LOW  = 7'h28;
    localparam logic [ADDR_W-1:0] Y_ANGLE_INCREMENT_HIGH = 7'h2A;
    localparam logic [ADDR_W-1:0] Z_ANGLE_INCREMENT_LOW  = 7'h2C;
    localparam logic [ADDR_W-1:0] Z_ANGLE_INCREMENT_HIGH = 7'h2E;
    localparam logic [ADDR_W-1:0] X_SPEED_INCREMENT_LOW  = 7'h30;
    localparam logic [ADDR_W-1:0] X_SPEED_INCREMENT_HIGH = 7'h32;
    localparam logic [ADDR_W-1:0] Y_SPEED_INCREMENT_LOW  = 7'h34;
    localparam logic [ADDR_W-1:0] Y_SPEED_INCREMENT_HIGH = 7'h36;

    // ========================================================
    // clamp a wide signed sum into the 32-bit result
    // ========================================================
    function automatic logic [RES_W-1:0] dvi_sat32(
        input logic signed [ACC_W-1:0] v);
        logic signed [ACC_W-1:0] hi;
        logic signed [ACC_W-1:0] lo;
        hi = ACC_W'(signed'(RES_POS_MAX));
        lo = -hi - ACC_W'(1);
        if (v > hi) begin
            dvi_sat32 = RES_POS_MAX;
        end else if (v < lo) begin
            dvi_sat32 = RES_NEG_MAX;
        end else begin
            dvi_sat32 = v[RES_W-1:0];
        end
    endfunction

endpackage

// [hw/dvi_trap_integ.sv]
`timescale 1ns/1ps
// ============================================================
// one axis trapezoidal integrator
// ============================================================
module dvi_trap_integ
    import dvi_pkg::*;
#(
    parameter int W = SAMPLE_W  // sample width
) (
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    input  wire logic                tick_i,    // new sample strobe
    input  wire logic                dump_i,    // close the update
    input  wire logic signed [W-1:0] sample_i,  // current sample
    output logic         [RES_W-1:0] result_o   // last finished update
);

    // ========================================================
    // state
    // ========================================================
    typedef struct packed {
        logic signed [W-1:0]     prev;    // predecessor sample
        logic signed [ACC_W-1:0] acc;     // running pair sum
        logic [RES_W-1:0]        result;  // held output
    } dvi_integ_t;

    dvi_integ_t              q;       // registered state
    dvi_integ_t              nxt_q;   // next state
    logic signed [ACC_W-1:0] pair;    // sample plus predecessor
    logic signed [ACC_W-1:0] total;   // sum including this pair

    // ========================================================
    // next state
    // ========================================================
    always_comb begin
        nxt_q = q;
        // each term is a sample plus its predecessor
        pair  = ACC_W'(sample_i) + ACC_W'(q.prev);
        total = q.acc + pair;
        if (tick_i) begin
            nxt_q.prev = sample_i;
            if (dump_i) begin
                // halve and clamp into the 32-bit word
                nxt_q.result = dvi_sat32(total >>> GAIN_SHIFT);
                nxt_q.acc    = '0;
            end else begin
                nxt_q.acc = total;
            end
        end
    end

    // ========================================================
    // state register
    // ========================================================
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            q <= '{prev: '0, acc: '0, result: RES_RST};
        end else begin
            q <= nxt_q;
        end
    end

    assign result_o = q.result;

    // ========================================================
    // checks
    // ========================================================
    property p_pair_accum;
        @(posedge clock_i) disable iff (!resetn_i)
        (tick_i && !dump_i) |=>
            (q.acc == $past(q.acc) + ACC_W'($past(sample_i))
                      + ACC_W'($past(q.prev)));
    endproperty
    a_pair_accum: assert property (p_pair_accum)
        else $error("accumulator missed a sample pair");

    property p_clamp_pos;
        @(posedge clock_i) disable iff (!resetn_i)
        (tick_i && dump_i && ((total >>> GAIN_SHIFT) >
            ACC_W'(signed'(RES_POS_MAX)))) |=>
            (result_o == RES_POS_MAX);
    endproperty
    a_clamp_pos: assert property (p_clamp_pos)
        else $error("positive overflow not clamped");

endmodule

// [hw/dvi_core.sv]
`timescale 1ns/1ps
// Operation
// - velocity is trapezoidal sum over D samples
// - D equals decimation setting plus one
// - internal sample rate is 2000 per second
// - angle low word is result bits 15:0
// - angle high word twos complement, zero zero
// - speed high word spans plus minus 400
// - speed low word extends high word resolution
// - high over low forms one 32-bit result
// - 32-bit form clamps to 7FFFFFFF / 80000000
// - 16-bit form 7FFF, 8000, minus one ones
// - angle words read only at 0x24 to 0x2E
// - speed words read only at 0x30 to 0x36
// - angle uses same trapezoid on rate samples
// - angle full scale 360, 720 or 2160
module dvi_core
    import dvi_pkg::*;
#(
    parameter int SAMPLE_DIV      = SAMPLE_DIV_CYC, // cycles per sample
    parameter int ANGLE_RANGE_DEG = 360             // model full scale
) (
    input  wire logic                       clock_i,
    input  wire logic                       resetn_i,
    input  wire logic signed [SAMPLE_W-1:0] gyro_x_i,
    input  wire logic signed [SAMPLE_W-1:0] gyro_y_i,
    input  wire logic signed [SAMPLE_W-1:0] gyro_z_i,
    input  wire logic signed [SAMPLE_W-1:0] accel_x_i,
    input  wire logic signed [SAMPLE_W-1:0] accel_y_i,
    input  wire logic        [DEC_W-1:0]    decimation_setting_i,
    input  wire logic                       reg_rd_i,
    input  wire logic        [ADDR_W-1:0]   reg_addr_i,
    output logic             [WORD_W-1:0]   reg_rdata_o,
    output logic                            reg_rvalid_o,
    output logic                            sample_tick_o,
    output logic                            sample_ready_pin_o
);

    // ========================================================
    // axis indices of the result array
    // ========================================================
    localparam int N_AXES = 5;  // three angle, two speed
    localparam int AX_GX  = 0;  // x angle
    localparam int AX_GY  = 1;  // y angle
    localparam int AX_GZ  = 2;  // z angle
    localparam int AX_AX  = 3;  // x speed
    localparam int AX_AY  = 4;  // y speed

    // ========================================================
    // state
    // ========================================================
    typedef struct packed {
        logic [DIV_W-1:0]  div_cnt;  // cycles into the sample period
        logic              tick;     // sample strobe
        logic [DEC_W-1:0]  dec_cnt;  // samples already summed
        logic              ready;    // update pulse
        logic [WORD_W-1:0] rdata;    // read data
        logic              rvalid;   // read data strobe
    } dvi_core_t;

    dvi_core_t                   q;        // registered state
    dvi_core_t                   nxt_q;    // next state
    logic                        dump;     // this sample closes update
    logic signed [SAMPLE_W-1:0]  samp [N_AXES]; // per axis samples
    logic        [RES_W-1:0]     word [N_AXES]; // per axis results

    // ========================================================
    // register read decode
    // ========================================================
    function automatic logic [WORD_W-1:0] read_word(
        input logic [ADDR_W-1:0] a,
        input logic [RES_W-1:0]  gx,
        input logic [RES_W-1:0]  gy,
        input logic [RES_W-1:0]  gz,
        input logic [RES_W-1:0]  ax,
        input logic [RES_W-1:0]  ay);
        logic [ADDR_W-2:0] w;
        w = a[ADDR_W-1:1];
        // low word is bits 15:0 of the result
        // high word 31:16, twos complement sign on top
        // both bytes of a word answer the same value
        if (w == X_ANGLE_INCREMENT_LOW[ADDR_W-1:1]) begin
            read_word = gx[WORD_W-1:0];
        end else if (w == X_ANGLE_INCREMENT_HIGH[ADDR_W-1:1]) begin
            read_word = gx[RES_W-1:WORD_W];
        end else if (w == Y_ANGLE_INCREMENT_LOW[ADDR_W-1:1]) begin
            read_word = gy[WORD_W-1:0];
        end else if (w == Y_ANGLE_INCREMENT_HIGH[ADDR_W-1:1]) begin
            read_word = gy[RES_W-1:WORD_W];
        end else if (w == Z_ANGLE_INCREMENT_LOW[ADDR_W-1:1]) begin
            read_word = gz[WORD_W-1:0];
        end else if (w == Z_ANGLE_INCREMENT_HIGH[ADDR_W-1:1]) begin
            read_word = gz[RES_W-1:WORD_W];
        end else if (w == X_SPEED_INCREMENT_LOW[ADDR_W-1:1]) begin
            read_word = ax[WORD_W-1:0];
        end else if (w == X_SPEED_INCREMENT_HIGH[ADDR_W-1:1]) begin
            read_word = ax[RES_W-1:WORD_W];
        end else if (w == Y_SPEED_INCREMENT_LOW[ADDR_W-1:1]) begin
            read_word = ay[WORD_W-1:0];
        end else if (w == Y_SPEED_INCREMENT_HIGH[ADDR_W-1:1]) begin
            read_word = ay[RES_W-1:WORD_W];
        end else begin
            // outside this block the answer is zero
            read_word = WORD_RST;
        end
    endfunction

    // ========================================================
    // per axis integrators
    // ========================================================
    assign samp[AX_GX] = gyro_x_i;
    assign samp[AX_GY] = gyro_y_i;
    assign samp[AX_GZ] = gyro_z_i;
    assign samp[AX_AX] = accel_x_i;
    assign samp[AX_AY] = accel_y_i;

    // update closes once D samples are
    assign dump = q.tick && (q.dec_cnt >= decimation_setting_i);

    // all axes share one tick and one dump
    for (genvar i = 0; i < N_AXES; i++) begin : g_axis
        dvi_trap_integ #(
            .W        (SAMPLE_W)
        ) u_integ (
            .clock_i  (clock_i),
            .resetn_i (resetn_i),
            .tick_i   (q.tick),
            .dump_i   (dump),
            .sample_i (samp[i]),
            .result_o (word[i])
        );
    end

    // ========================================================
    // next state
    // ========================================================
    always_comb begin
        nxt_q        = q;
        nxt_q.tick   = 1'b0;
        nxt_q.ready  = 1'b0;
        nxt_q.rvalid = 1'b0;
        // sample period divider
        if (q.div_cnt == DIV_W'(SAMPLE_DIV - 1)) begin
            nxt_q.div_cnt = '0;
            nxt_q.tick    = 1'b1;
        end else begin
            nxt_q.div_cnt = q.div_cnt + DIV_W'(1);
        end
        // decimation count, restarts at each update
        if (q.tick) begin
            if (dump) begin
                nxt_q.dec_cnt = '0;
                nxt_q.ready   = 1'b1;
            end else begin
                nxt_q.dec_cnt = q.dec_cnt + DEC_W'(1);
            end
        end
        // read only words, writes have no path here
        if (reg_rd_i) begin
            nxt_q.rdata  = read_word(reg_addr_i, word[AX_GX],
                word[AX_GY], word[AX_GZ], word[AX_AX], word[AX_AY]);
            nxt_q.rvalid = 1'b1;
        end
    end

    // ========================================================
    // state register
    // ========================================================
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            q <= '{div_cnt: '0, tick: 1'b0, dec_cnt: '0, ready: 1'b0,
                   rdata: WORD_RST, rvalid: 1'b0};
        end else begin
            q <= nxt_q;
        end
    end

    // ========================================================
    // outputs
    // ========================================================
    assign reg_rdata_o        = q.rdata;
    assign reg_rvalid_o       = q.rvalid;
    assign sample_tick_o      = q.tick;
    assign sample_ready_pin_o = q.ready;

    // ========================================================
    // checks
    // ========================================================
    property p_tick_period;
        @(posedge clock_i) disable iff (!resetn_i)
        (q.div_cnt == DIV_W'(SAMPLE_DIV - 1)) |=>
            (q.tick && q.div_cnt == '0);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("sample tick not at divider wrap");

    property p_tick_only_wrap;
        @(posedge clock_i) disable iff (!resetn_i)
        q.tick |-> ($past(q.div_cnt) == DIV_W'(SAMPLE_DIV - 1));
    endproperty
    a_tick_only_wrap: assert property (p_tick_only_wrap)
        else $error("sample tick away from divider wrap");

    property p_dec_update;
        @(posedge clock_i) disable iff (!resetn_i)
        q.tick |=> (q.ready ==
            ($past(q.dec_cnt) >= $past(decimation_setting_i)));
    endproperty
    a_dec_update: assert property (p_dec_update)
        else $error("update not after decimation count");

    property p_joint_load;
        @(posedge clock_i) disable iff (!resetn_i)
        !q.ready && $past(!q.ready) |->
            (word[AX_GX] == $past(word[AX_GX]) &&
             word[AX_AY] == $past(word[AX_AY]));
    endproperty
    a_joint_load: assert property (p_joint_load)
        else $error("result changed outside an update");

    property p_angle_low;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == X_ANGLE_INCREMENT_LOW) |=>
            (reg_rvalid_o && reg_rdata_o ==
             $past(word[AX_GX][WORD_W-1:0]));
    endproperty
    a_angle_low: assert property (p_angle_low)
        else $error("angle low word wrong");

    property p_angle_high;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == Z_ANGLE_INCREMENT_HIGH) |=>
            (reg_rdata_o == $past(word[AX_GZ][RES_W-1:WORD_W]));
    endproperty
    a_angle_high: assert property (p_angle_high)
        else $error("angle high word wrong");

    property p_speed_words;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == Y_SPEED_INCREMENT_HIGH) |=>
            (reg_rdata_o == $past(word[AX_AY][RES_W-1:WORD_W]));
    endproperty
    a_speed_words: assert property (p_speed_words)
        else $error("speed high word wrong");

    property p_unmapped;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i[ADDR_W-1:1] == 6'h1C) |=>
            (reg_rdata_o == WORD_RST);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_range;
        @(posedge clock_i) disable iff (!resetn_i)
        (ANGLE_RANGE_DEG == 360 || ANGLE_RANGE_DEG == 720 ||
         ANGLE_RANGE_DEG == 2160);
    endproperty
    a_range: assert property (p_range)
        else $error("angle full scale not a model value");

    property p_angle_high_x;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == X_ANGLE_INCREMENT_HIGH) |=>
            (reg_rdata_o == $past(word[AX_GX][RES_W-1:WORD_W]));
    endproperty
    a_angle_high_x: assert property (p_angle_high_x)
        else $error("x angle high word wrong");

    property p_speed_high_x;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == X_SPEED_INCREMENT_HIGH) |=>
            (reg_rdata_o == $past(word[AX_AX][RES_W-1:WORD_W]));
    endproperty
    a_speed_high_x: assert property (p_speed_high_x)
        else $error("x speed high word wrong");

    property p_speed_low_x;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == X_SPEED_INCREMENT_LOW) |=>
            (reg_rdata_o == $past(word[AX_AX][WORD_W-1:0]));
    endproperty
    a_speed_low_x: assert property (p_speed_low_x)
        else $error("x speed low word wrong");

    property p_odd_byte;
        @(posedge clock_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == (Y_ANGLE_INCREMENT_LOW + 7'h01)) |=>
            (reg_rdata_o == $past(word[AX_GY][WORD_W-1:0]));
    endproperty
    a_odd_byte: assert property (p_odd_byte)
        else $error("odd byte of a word answered differently");

    property p_read_answer;
        @(posedge clock_i) disable iff (!resetn_i)
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read request not answered next cycle");

    property p_read_quiet;
        @(posedge clock_i) disable iff (!resetn_i)
        !reg_rd_i |=> !reg_rvalid_o;
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("read data strobe without a request");

endmodule

// [dv/dvi_host_model.sv]
`timescale 1ns/1ps
// ==========================================================
// host side model: reads result words, watches data ready
// ==========================================================
module dvi_host_model
    import dvi_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              reg_rvalid_i,
    input  wire logic [WORD_W-1:0] reg_rdata_i,
    input  wire logic              ready_i,
    output logic                   reg_rd_o,
    output logic      [ADDR_W-1:0] reg_addr_o
);
    // idle bus at time zero
    initial begin
        reg_rd_o   = 1'b0;
        reg_addr_o = 7'h00;
    end

    // one read: strobe held over the taking edge, data taken
    // at the edge where valid is high
    task automatic rd(input  logic [ADDR_W-1:0] a,
                      output logic [WORD_W-1:0] d);
        @(posedge clock_i);
        #2;
        reg_rd_o   = 1'b1;
        reg_addr_o = a;
        @(posedge clock_i);
        #2;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a; // released address never shows the old one
        @(posedge clock_i);
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 'x;
    endtask

    // cycles until the next ready pulse, bounded
    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            #2;
            n++;
        end while (ready_i !== 1'b1 && n < 2000);
    endtask

    // ready period with decimation zero gives the true rate
    task automatic period(output int n);
        wait_ready(n);
        wait_ready(n);
    endtask
endmodule

// [dv/tb_delta_angle_velocity_integrator.sv]
`timescale 1ns/1ps
// ==========================================================
// testbench for the delta angle / delta velocity block
// ==========================================================
module tb_delta_angle_velocity_integrator
    import dvi_pkg::*;
;
    localparam int SDIV = 32; // short sample period

    logic                       clock_i;
    logic                       resetn_i;
    logic signed [SAMPLE_W-1:0] smp [5];   // gx gy gz ax ay
    logic        [DEC_W-1:0]    dec;       // decimation setting
    logic                       rd;
    logic        [ADDR_W-1:0]   addr;
    logic        [WORD_W-1:0]   rdata;
    logic                       rvalid;
    logic                       tick;
    logic                       ready;
    int                         bad_count;
    int                         n_compared;
    int                         n_ticks;   // sample strobes seen

    // low word addresses, same order as the samples
    localparam logic [ADDR_W-1:0] LOWS [5] = '{
        X_ANGLE_INCREMENT_LOW, Y_ANGLE_INCREMENT_LOW,
        Z_ANGLE_INCREMENT_LOW, X_SPEED_INCREMENT_LOW,
        Y_SPEED_INCREMENT_LOW};

    dvi_core #(
        .SAMPLE_DIV (SDIV)
    ) dut_u (
        .clock_i              (clock_i),
        .resetn_i             (resetn_i),
        .gyro_x_i             (smp[0]),
        .gyro_y_i             (smp[1]),
        .gyro_z_i             (smp[2]),
        .accel_x_i            (smp[3]),
        .accel_y_i            (smp[4]),
        .decimation_setting_i (dec),
        .reg_rd_i             (rd),
        .reg_addr_i           (addr),
        .reg_rdata_o          (rdata),
        .reg_rvalid_o         (rvalid),
        .sample_tick_o        (tick),
        .sample_ready_pin_o   (ready)
    );

    dvi_host_model host_u (
        .clock_i      (clock_i),
        .reg_rvalid_i (rvalid),
        .reg_rdata_i  (rdata),
        .ready_i      (ready),
        .reg_rd_o     (rd),
        .reg_addr_o   (addr)
    );

    // ======================================================
    // clock and shared tasks
    // ======================================================
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // count sample strobes to check the decimation window
    always @(posedge clock_i) begin
        if (tick === 1'b1) begin
            n_ticks <= n_ticks + 1;
        end
    end

    task automatic check_word(input logic [WORD_W-1:0] got,
                              input logic [WORD_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected word at %0t: got %h exp %h",
                     $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected count at %0t: got %h exp %h",
                     $time, got, exp);
        end
    endtask

    // expected result: d pairs of (a + b), halved
    function automatic logic [RES_W-1:0] trap(int d, int a, int b);
        int s;
        s = d * (a + b);
        return RES_W'(s >>> 1);
    endfunction

    // read low then high word of one result and compare
    task automatic check_res(input int i, input logic [RES_W-1:0] e);
        logic [WORD_W-1:0] d;
        host_u.rd(LOWS[i], d);
        check_word(d, e[15:0]);
        host_u.rd(LOWS[i] + 7'h02, d);
        check_word(d, e[31:16]);
    endtask

    // drive all five samples just after an edge
    task automatic set_smp(input int v [5]);
        @(posedge clock_i);
        #2;
        foreach (smp[i]) smp[i] = SAMPLE_W'(v[i]);
    endtask

    task automatic do_reset();
        @(posedge clock_i);
        #2;
        resetn_i = 1'b0;
        repeat (12) @(posedge clock_i);
        #2;
        resetn_i = 1'b1;
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ======================================================
    // scenarios
    // ======================================================
    // all words zero after reset, unmapped and odd addresses
    task automatic t_reset_values();
        logic [WORD_W-1:0] d;
        for (int i = 0; i < 5; i++) check_res(i, RES_RST);
        host_u.rd(7'h3C, d);
        check_word(d, WORD_RST);
        host_u.rd(X_ANGLE_INCREMENT_LOW + 7'h01, d);
        check_word(d, WORD_RST);
    endtask

    // trapezoid from reset, then a step in every sample
    task automatic t_trapezoid();
        int v0 [5] = '{100, -200, 301, -4, 32767};
        int v1 [5] = '{-32768, 5, -301, 4, -1};
        int n;
        do_reset();
        dec = 16'h0000;
        foreach (smp[i]) smp[i] = SAMPLE_W'(v0[i]);
        host_u.wait_ready(n);
        for (int i = 0; i < 5; i++) begin
            check_res(i, trap(1, v0[i], 0));
        end
        host_u.period(n);
        check_count(n, SDIV);
        set_smp(v1);
        host_u.wait_ready(n);
        check_res(0, trap(1, v1[0], v0[0]));
        check_res(3, trap(1, v1[3], v0[3]));
        host_u.wait_ready(n);
        for (int i = 0; i < 5; i++) begin
            check_res(i, trap(1, v1[i], v1[i]));
        end
    endtask

    // decimated sums and the update period they give
    task automatic t_decimation();
        int v [5] = '{1000, -1000, 7, -7, 2};
        int n;
        int dd;
        int t0;
        set_smp(v);
        for (int k = 0; k < 2; k++) begin
            dd = (k == 0) ? 1 : 3;
            @(posedge clock_i);
            #2;
            dec = DEC_W'(dd);
            host_u.wait_ready(n);
            host_u.period(n);
            check_count(n, (dd + 1) * SDIV);
            for (int i = 0; i < 5; i++) begin
                check_res(i, trap(dd + 1, v[i], v[i]));
            end
            t0 = n_ticks;
            host_u.wait_ready(n);
            check_count(n_ticks - t0, dd + 1);
        end
    endtask

    // ======================================================
    // main sequence and watchdog
    // ======================================================
    initial begin
        bad_count  = 0;
        n_compared = 0;
        n_ticks    = 0;
        resetn_i   = 1'b0;
        dec        = 16'h0000;
        foreach (smp[i]) smp[i] = 16'h0000;
        do_reset();
        t_reset_values();
        t_trapezoid();
        t_decimation();
        print_verdict();
    end

    // a hang counts as a mismatch
    initial begin
        #(25 * 8000);
        bad_count++;
        print_verdict();
    end
endmodule
